//--- pkg/lin_slave_consts.vh
// Constants of the slave header and resynchronisation block.
// Included by bare name; defines only.
`ifndef LIN_SLAVE_CONSTS_VH
`define LIN_SLAVE_CONSTS_VH
`define OVERSAMPLE        5'd16
`define SAMPLE_A          4'h7
`define SAMPLE_B          4'h8
`define SAMPLE_C          4'h9
`define LAST_SAMPLE       4'hF
`define BREAK_TICKS       8'hB0
`define HDR_MAX_TICKS     11'h390
`define SYNCH_VALUE       8'h55
`define SYNCH_LAST_EDGE   3'h4
`define DEV_SHIFT         6
`define DEV_NUM           5'd10
`define DIV_RESET         12'h000
`define H_SRCH            2'h0
`define H_SYNC            2'h1
`define H_ID              2'h2
`define H_BLK             2'h3
`define R_IDLE            3'h0
`define R_START           3'h1
`define R_DATA            3'h2
`define R_STOP            3'h3
`define R_WAITH           3'h4
`endif

//--- hw/lin_rate_gen.v
// Fractional rate generator giving one tick per divider clocks (8.4 fixed point).
// Assumes a single clock; a divider of zero stops the ticks.
`timescale 1ns/1ps
`include "lin_slave_consts.vh"
module lin_rate_gen
(
	input  wire        i_ref_clk,
	input  wire        i_rst,
	input  wire        i_ce,
	input  wire        i_restart,
	input  wire [11:0] i_div,
	output reg         o_tick
);
	reg  [12:0] acc_r;
	wire [12:0] acc_add = acc_r + {8'h00, `OVERSAMPLE};

	// Adding one whole clock in sixteenths keeps the fraction exact over a frame.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			acc_r  <= 13'h0000;
			o_tick <= 1'b0;
		end
		else if (i_ce)
		begin
			if (i_restart || i_div == 12'h000)
			begin
				acc_r  <= 13'h0000;
				o_tick <= 1'b0;
			end
			else if (acc_add >= {1'b0, i_div})
			begin
				acc_r  <= acc_add - {1'b0, i_div};
				o_tick <= 1'b1;
			end
			else
			begin
				acc_r  <= acc_add;
				o_tick <= 1'b0;
			end
		end
	end
endmodule // lin_rate_gen

//--- hw/lin_slave_header_resync.v
// Slave-side header checker, mute wake-up and synch-field divider resynchronisation.
// Assumes software strobes arrive as one-cycle pulses on i_ref_clk; i_rdi is a raw pin.
`timescale 1ns/1ps
`include "lin_slave_consts.vh"
// How it works
// - Header error sets its flag; interrupt when enabled and both masks clear.
// - Status access followed by data read clears the header error flag unless synch field state set.
// - Without resync: wrong synch byte, overrun, and timeout with identifier mode flag.
// - Resync: span of five synch edges deviating over 15.625 percent flags error.
// - First and last synch bit pair too short versus current rate flags error and blocks.
// - Measurement overflow flags and blocks; synch field itself never flags overrun; with both mode bits clear an unread break character lets it flag.
// - Header longer than 57 local bits flags error when either mode bit set.
// - Timeout counter starts at break, stops at identifier, error or synch exit.
// - Timeout in resync synch blocks; elsewhere header discarded, new break sought.
// - Header length readable only with identifier mode or resync enabled.
// - Mute with identifier mode: synch error or timeout flags without waking.
// - Mute discards non-break framing errors; framing flag stays clear.
// - Identifier mode wakes only on break, clean synch, clean identifier, no timeout.
// - Break needs at least 11 local bit times low; nine low bits never.
// - Resync counts clocks over five falling edges, loads divider at fifth.
// - Receiver halted during synch measurement; nothing reaches the data register.
// - Slave mode drives transmit and receive from clock over 16 times divider.
// - Divider is 8-bit mantissa with 4-bit fraction.
// - Nominal, measured and active dividers kept; nominal write wins a tie.
// - Master mode takes its rate from the external prescaler value.
// - Sixteen samples per bit, majority of eighth to tenth, realign per start.
// - Update method clear loads at mantissa write, set waits for next character.
module lin_slave_header_resync
(
	input  wire        i_ref_clk,
	input  wire        i_rst,
	input  wire        i_ce,
	input  wire        i_rdi,
	input  wire        i_line_en,
	input  wire        i_slave_sel,
	input  wire        i_auto_resync_en,
	input  wire        i_header_detect_method,
	input  wire        i_div_update_method,
	input  wire        i_rx_irq_en,
	input  wire [1:0]  i_ccr_mask,
	input  wire [11:0] i_master_div,
	input  wire        i_mant_wr,
	input  wire [7:0]  i_mant_data,
	input  wire        i_frac_wr,
	input  wire [3:0]  i_frac_data,
	input  wire        i_status_access,
	input  wire        i_data_read,
	input  wire        i_lsf_clear,
	input  wire        i_hdf_clear,
	input  wire        i_mute_set,
	input  wire        i_mute_clear,
	output reg         o_header_error_flag,
	output reg         o_irq,
	output reg         o_synch_field_state,
	output reg         o_header_detected,
	output reg         o_rx_full,
	output reg  [7:0]  o_rx_data,
	output reg         o_framing_error_flag,
	output reg         o_mute,
	output reg  [7:0]  o_header_length,
	output reg  [11:0] o_lin_divider,
	output wire        o_tx_tick
);
	reg         rdi_s1_r, rdi_s2_r, rdi_d_r;
	reg  [11:0] nominal_divider_r;
	reg         pend_ld_r;
	reg  [1:0]  hs_r;
	reg  [2:0]  rs_r;
	reg  [3:0]  samp_r;
	reg  [2:0]  bit_r;
	reg  [7:0]  shift_r;
	reg         sa_r, sb_r;
	reg  [7:0]  low_cnt_r;
	reg         ev_r, ev_fe_r, brk_r;
	reg  [7:0]  ev_byte_r;
	reg         hdr_run_r;
	reg  [10:0] hdr_ticks_r;
	reg  [14:0] synch_measure_counter_r, iv_r;
	reg  [2:0]  edge_r;
	reg         wait_hi_r, status_seen_r;
	wire        rx = rdi_s2_r;
	wire        fall = rdi_d_r & ~rx;
	wire        slave = i_line_en & i_slave_sel;
	wire        timed = i_header_detect_method | i_auto_resync_en;
	wire        meas_act = (hs_r == `H_SYNC) & i_auto_resync_en;
	wire        rx_run = ~meas_act & ~wait_hi_r & (hs_r != `H_BLK);
	wire        rx_tick, free_tick;
	wire        maj = (sa_r & sb_r) | (sa_r & rx) | (sb_r & rx);
	wire [11:0] rate_div = slave ? o_lin_divider : i_master_div;
	wire        start_seen = (rs_r == `R_IDLE) & rx_run & fall;
	wire [11:0] measured_divider = synch_measure_counter_r[14:3];
	wire [14:0] nom_span = {o_lin_divider, 3'h0};
	wire [14:0] dev_abs = (synch_measure_counter_r > nom_span) ?
		synch_measure_counter_r - nom_span : nom_span - synch_measure_counter_r;
	wire [20:0] dev_lhs = {dev_abs, 6'h00};
	wire [20:0] dev_rhs = {6'h00, nom_span} * {16'h0000, `DEV_NUM};
	wire        dev_err = dev_lhs > dev_rhs;
	wire [16:0] iv_x4 = {iv_r, 2'h0};
	wire [16:0] pair_x3 = {4'h0, o_lin_divider, 1'b0} * 17'h00003;
	wire        bit_err = iv_x4 < pair_x3;
	wire        sm_ovf = &synch_measure_counter_r;
	wire        tmo = hdr_run_r & (hdr_ticks_r > `HDR_MAX_TICKS);
	wire        nom_ld = i_mant_wr & ~i_div_update_method;

	lin_rate_gen u_rx_rate
	(
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_restart (start_seen),
		.i_div     (rate_div),
		.o_tick    (rx_tick)
	);

	lin_rate_gen u_tx_rate
	(
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_restart (1'b0),
		.i_div     (rate_div),
		.o_tick    (free_tick)
	);
	assign o_tx_tick = free_tick;

	// Receive bit engine; the break length is judged from the low counter, not the frame.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			rdi_s1_r  <= 1'b1;
			rdi_s2_r  <= 1'b1;
			rdi_d_r   <= 1'b1;
			rs_r      <= `R_IDLE;
			samp_r    <= 4'h0;
			bit_r     <= 3'h0;
			shift_r   <= 8'h00;
			sa_r      <= 1'b0;
			sb_r      <= 1'b0;
			low_cnt_r <= 8'h00;
			ev_r      <= 1'b0;
			ev_fe_r   <= 1'b0;
			ev_byte_r <= 8'h00;
			brk_r     <= 1'b0;
		end
		else if (i_ce)
		begin
			rdi_s1_r <= i_rdi;
			rdi_s2_r <= rdi_s1_r;
			rdi_d_r  <= rdi_s2_r;
			ev_r     <= 1'b0;
			brk_r    <= 1'b0;
			if (rx)
				low_cnt_r <= 8'h00;
			else if (free_tick && low_cnt_r != 8'hFF)
				low_cnt_r <= low_cnt_r + 8'h01;
			if (!rx_run)
				rs_r <= `R_IDLE;
			else if (start_seen)
			begin
				rs_r   <= `R_START;
				samp_r <= 4'h0;
			end
			else if (rs_r == `R_WAITH)
			begin
				if (rx)
				begin
					rs_r <= `R_IDLE;
					if (low_cnt_r >= `BREAK_TICKS)
						brk_r <= 1'b1;
					else
					begin
						ev_r      <= 1'b1;
						ev_fe_r   <= 1'b1;
						ev_byte_r <= 8'h00;
					end
				end
			end
			else if (rs_r != `R_IDLE && rx_tick)
			begin
				samp_r <= samp_r + 4'h1;
				if (samp_r == `SAMPLE_A)
					sa_r <= rx;
				if (samp_r == `SAMPLE_B)
					sb_r <= rx;
				if (samp_r == `SAMPLE_C)
				begin
					if (rs_r == `R_START)
					begin
						if (maj)
							rs_r <= `R_IDLE;
					end
					else if (rs_r == `R_DATA)
						shift_r <= {maj, shift_r[7:1]};
					else if (maj)
					begin
						rs_r      <= `R_IDLE;
						ev_r      <= 1'b1;
						ev_fe_r   <= 1'b0;
						ev_byte_r <= shift_r;
					end
					else if (shift_r == 8'h00)
						rs_r <= `R_WAITH;
					else
					begin
						rs_r      <= `R_IDLE;
						ev_r      <= 1'b1;
						ev_fe_r   <= 1'b1;
						ev_byte_r <= shift_r;
					end
				end
				if (samp_r == `LAST_SAMPLE)
				begin
					if (rs_r == `R_START)
					begin
						rs_r  <= `R_DATA;
						bit_r <= 3'h0;
					end
					else if (rs_r == `R_DATA)
					begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7)
							rs_r <= `R_STOP;
					end
				end
			end
		end
	end

	// Header sequencing, flags and dividers. Later assignments in this block take priority.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			hs_r                    <= `H_SRCH;
			hdr_run_r               <= 1'b0;
			hdr_ticks_r             <= 11'h000;
			synch_measure_counter_r <= 15'h0000;
			iv_r                    <= 15'h0000;
			edge_r                  <= 3'h0;
			wait_hi_r               <= 1'b0;
			status_seen_r           <= 1'b0;
			nominal_divider_r       <= `DIV_RESET;
			pend_ld_r               <= 1'b0;
			o_lin_divider           <= `DIV_RESET;
			o_header_error_flag     <= 1'b0;
			o_irq                   <= 1'b0;
			o_synch_field_state     <= 1'b0;
			o_header_detected       <= 1'b0;
			o_rx_full               <= 1'b0;
			o_rx_data               <= 8'h00;
			o_framing_error_flag    <= 1'b0;
			o_mute                  <= 1'b0;
			o_header_length         <= 8'h00;
		end
		else if (i_ce)
		begin
			o_irq <= o_header_error_flag & i_rx_irq_en & (i_ccr_mask == 2'h0);
			o_header_length <= timed ? {1'b0, hdr_ticks_r[10:4]} : 8'h00;
			if (rx)
				wait_hi_r <= 1'b0;
			if (i_status_access)
				status_seen_r <= 1'b1;
			if (i_data_read)
			begin
				status_seen_r <= 1'b0;
				o_rx_full     <= 1'b0;
				if (status_seen_r)
				begin
					o_framing_error_flag <= 1'b0;
					if (!o_synch_field_state)
						o_header_error_flag <= 1'b0;
				end
			end
			if (i_hdf_clear)
				o_header_detected <= 1'b0;
			if (!(o_rx_full && slave))
			begin
				if (i_mute_set)
					o_mute <= 1'b1;
				if (i_mute_clear)
					o_mute <= 1'b0;
			end
			if (i_frac_wr)
				nominal_divider_r[3:0] <= i_frac_data;
			if (i_mant_wr)
			begin
				nominal_divider_r[11:4] <= i_mant_data;
				pend_ld_r               <= i_div_update_method;
			end
			if (hdr_run_r && free_tick && hdr_ticks_r != 11'h7FF)
				hdr_ticks_r <= hdr_ticks_r + 11'h001;
			if (i_lsf_clear && o_synch_field_state)
			begin
				o_synch_field_state <= 1'b0;
				hs_r                <= `H_SRCH;
				hdr_run_r           <= 1'b0;
			end
			else if (slave && brk_r && hs_r != `H_BLK)
			begin
				hs_r                <= `H_SYNC;
				hdr_run_r           <= 1'b1;
				hdr_ticks_r         <= {3'h0, low_cnt_r};
				edge_r              <= 3'h0;
				o_synch_field_state <= i_auto_resync_en;
				if (!i_header_detect_method)
				begin
					o_rx_full         <= 1'b1;
					o_rx_data         <= 8'h00;
					o_header_detected <= 1'b1;
					o_mute            <= 1'b0;
				end
			end
			else if (tmo && timed)
			begin
				o_header_error_flag <= 1'b1;
				hdr_run_r           <= 1'b0;
				if (meas_act)
					hs_r <= `H_BLK;
				else
				begin
					hs_r                <= `H_SRCH;
					o_synch_field_state <= 1'b0;
				end
			end
			else if (meas_act)
			begin
				if (!sm_ovf)
					synch_measure_counter_r <= synch_measure_counter_r + 15'h0001;
				if (iv_r != 15'h7FFF)
					iv_r <= iv_r + 15'h0001;
				if (sm_ovf && edge_r != 3'h0)
				begin
					o_header_error_flag <= 1'b1;
					hdr_run_r           <= 1'b0;
					hs_r                <= `H_BLK;
				end
				else if (fall)
				begin
					iv_r   <= 15'h0000;
					edge_r <= edge_r + 3'h1;
					// Starting at one makes the count equal the clocks between first and fifth fall.
					if (edge_r == 3'h0)
						synch_measure_counter_r <= 15'h0001;
					else if ((edge_r == 3'h1 || edge_r == `SYNCH_LAST_EDGE) && bit_err)
					begin
						o_header_error_flag <= 1'b1;
						hdr_run_r           <= 1'b0;
						hs_r                <= `H_BLK;
					end
					else if (edge_r == `SYNCH_LAST_EDGE)
					begin
						wait_hi_r           <= 1'b1;
						o_synch_field_state <= 1'b0;
						if (dev_err)
						begin
							o_header_error_flag <= 1'b1;
							hdr_run_r           <= 1'b0;
							hs_r                <= `H_SRCH;
						end
						else
						begin
							hs_r          <= `H_ID;
							o_lin_divider <= measured_divider;
						end
					end
				end
			end
			else if (ev_r)
			begin
				if (!o_mute && ev_fe_r)
					o_framing_error_flag <= 1'b1;
				if (hs_r == `H_SYNC && slave)
				begin
					if (ev_fe_r || ev_byte_r != `SYNCH_VALUE)
					begin
						o_header_error_flag <= 1'b1;
						hdr_run_r           <= 1'b0;
						hs_r                <= `H_SRCH;
					end
					else
						hs_r <= `H_ID;
				end
				else if (hs_r == `H_ID && slave)
				begin
					hdr_run_r <= 1'b0;
					hs_r      <= `H_SRCH;
					if (i_header_detect_method && !ev_fe_r)
					begin
						o_header_detected <= 1'b1;
						o_mute            <= 1'b0;
					end
				end
				if (!o_mute && !(i_header_detect_method && hs_r == `H_SYNC && slave) &&
					!(i_header_detect_method && ev_fe_r && hs_r == `H_ID))
				begin
					o_rx_full <= 1'b1;
					o_rx_data <= ev_byte_r;
					if (o_rx_full)
						o_header_error_flag <= 1'b1;
					if (pend_ld_r)
					begin
						o_lin_divider <= nominal_divider_r;
						pend_ld_r     <= 1'b0;
					end
				end
				else if (i_header_detect_method && hs_r == `H_ID && !ev_fe_r && slave)
				begin
					o_rx_full <= 1'b1;
					o_rx_data <= ev_byte_r;
				end
			end
			if (nom_ld)
				o_lin_divider <= {i_mant_data, nominal_divider_r[3:0]};
		end
	end
endmodule // lin_slave_header_resync

//--- verification/lin_master_model.sv
// Behavioural LIN master that drives the slave's receive pin.
// Assumes the bench sets bit_t, in clocks per bit, before each field.
`timescale 1ns/1ps
module lin_master_model
(
	input  wire logic i_ref_clk,
	output logic      o_rdi
);
	int bit_t = 32;
	// The bus has a pull-up, so a released line reads recessive high.
	initial o_rdi = 1'b1;
	task automatic hold(input int n, input logic lvl);
		o_rdi <= lvl;
		repeat (n * bit_t) @(posedge i_ref_clk);
	endtask
	task automatic brk();
		hold(13, 1'b0);
		hold(1, 1'b1);
	endtask
	task automatic byte_out(input logic [7:0] b, input logic stp);
		hold(1, 1'b0);
		for (int i = 0; i < 8; i++)
			hold(1, b[i]);
		hold(1, stp);
		// A dominant stop bit is followed by one recessive bit so the line ends released.
		if (!stp)
			hold(1, 1'b1);
	endtask
endmodule // lin_master_model

//--- verification/lin_slave_header_resync_asserts.sv
// Port checks for the slave header and resynchronisation block.
// Assumes a single clock and a clock enable held high.
`timescale 1ns/1ps
module lin_slave_header_resync_asserts
(
	input wire        i_ref_clk,
	input wire        i_rst,
	input wire        i_line_en,
	input wire        i_slave_sel,
	input wire        i_auto_resync_en,
	input wire        i_header_detect_method,
	input wire        i_div_update_method,
	input wire        i_rx_irq_en,
	input wire [1:0]  i_ccr_mask,
	input wire        i_mant_wr,
	input wire [7:0]  i_mant_data,
	input wire        o_header_error_flag,
	input wire        o_irq,
	input wire        o_synch_field_state,
	input wire        o_rx_full,
	input wire        o_framing_error_flag,
	input wire        o_mute,
	input wire [7:0]  o_header_length,
	input wire [11:0] o_lin_divider,
	input wire        o_tx_tick
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	wire slv = i_line_en && i_slave_sel;
	a_irq_follows_flag: assert property (!$past(i_rst) |-> o_irq ==
		$past(o_header_error_flag && i_rx_irq_en && i_ccr_mask == 2'b00)) else $error("irq");
	a_mant_loads_div: assert property (slv && i_mant_wr && !i_div_update_method
		|=> o_lin_divider[11:4] == $past(i_mant_data)) else $error("mantissa load");
	a_blocked_keeps_flag: assert property (o_synch_field_state && o_header_error_flag
		|=> o_header_error_flag) else $error("flag left blocked state");
	a_mute_no_fe: assert property (o_mute && !o_framing_error_flag
		|=> !o_framing_error_flag) else $error("framing flag in mute");
	a_len_gated: assert property ((!i_header_detect_method && !i_auto_resync_en)[*2]
		|-> o_header_length == 8'h00) else $error("header length shown");
	a_synch_needs_resync: assert property ($rose(o_synch_field_state)
		|-> $past(i_auto_resync_en)) else $error("synch state without resync");
	a_rx_halted: assert property (o_synch_field_state |=> !$rose(o_rx_full))
		else $error("character during synch");
	a_no_tick_zero: assert property ((slv && o_lin_divider == 12'h000)[*3]
		|-> !o_tx_tick) else $error("tick with zero divider");
endmodule // lin_slave_header_resync_asserts
bind lin_slave_header_resync lin_slave_header_resync_asserts chk (.*);

//--- verification/lin_slave_header_resync_test.sv
// Directed bench for the slave header and resynchronisation block.
// Assumes the master model drives the pin; strobes are one-cycle pulses.
`timescale 1ns/1ps
module lin_slave_header_resync_test;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_line_en = 1'b1, i_slave_sel = 1'b0;
	logic i_auto_resync_en = 1'b0, i_header_detect_method = 1'b0, i_div_update_method = 1'b0;
	logic i_rx_irq_en = 1'b1, i_rdi;
	// One pulse vector keeps every strobe on a single driver.
	logic [7:0] pulse = 8'h00;
	localparam int k_frac = 0, k_mant = 1, k_stat = 2, k_read = 3;
	localparam int k_lsf = 4, k_hdf = 5, k_mset = 6, k_mclr = 7;
	wire i_frac_wr = pulse[k_frac], i_mant_wr = pulse[k_mant];
	wire i_status_access = pulse[k_stat], i_data_read = pulse[k_read];
	wire i_lsf_clear = pulse[k_lsf], i_hdf_clear = pulse[k_hdf];
	wire i_mute_set = pulse[k_mset], i_mute_clear = pulse[k_mclr];
	logic [1:0] i_ccr_mask = 2'b00;
	logic [11:0] i_master_div = 12'h030;
	logic [7:0] i_mant_data = 8'h02;
	logic [3:0] i_frac_data = 4'h8;
	wire o_header_error_flag, o_irq, o_synch_field_state, o_header_detected, o_rx_full;
	wire o_framing_error_flag, o_mute, o_tx_tick;
	wire [7:0] o_rx_data, o_header_length;
	wire [11:0] o_lin_divider;
	int errors = 0, cmp_count = 0, cyc = 0;
	lin_slave_header_resync dut (.*);
	lin_master_model m (.i_ref_clk(i_ref_clk), .o_rdi(i_rdi));
	always #5 i_ref_clk = ~i_ref_clk;
	task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic strobe(input int k);
		pulse <= 8'h01 << k;
		@(posedge i_ref_clk);
		pulse <= 8'h00;
		@(posedge i_ref_clk);
	endtask
	// Counting from just after a tick keeps the window phase-exact for fractions.
	task automatic rate(input int w, input string nm);
		int n = 0;
		while (o_tx_tick !== 1'b1)
			@(posedge i_ref_clk);
		repeat (w)
		begin
			@(posedge i_ref_clk);
			if (o_tx_tick === 1'b1)
				n++;
		end
		check(nm, n, 16);
	endtask
	task automatic clr_seq();
		strobe(k_stat);
		strobe(k_read);
	endtask
	task automatic header(input logic [7:0] sy);
		m.brk();
		m.byte_out(sy, 1'b1);
		m.byte_out(8'h3C, 1'b1);
		repeat (60) @(posedge i_ref_clk);
	endtask
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			test_done();
		end
	end
	initial
	begin
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		check("reset div", o_lin_divider, 12'h000);
		check("reset flags", {o_header_error_flag, o_mute, o_rx_full}, 3'b000);
		rate(48, "master rate");
		i_slave_sel <= 1'b1;
		strobe(k_frac);
		check("frac alone", o_lin_divider, 12'h000);
		strobe(k_mant);
		check("div load", o_lin_divider, 12'h028);
		rate(40, "slave rate");
		m.bit_t = 40;
		m.brk();
		repeat (8) @(posedge i_ref_clk);
		check("break seen", {o_header_detected, o_rx_full, o_rx_data}, 10'h300);
		strobe(k_read);
		m.byte_out(8'h54, 1'b1);
		repeat (40) @(posedge i_ref_clk);
		check("bad synch", {o_header_error_flag, o_irq}, 2'b11);
		i_ccr_mask <= 2'b01;
		repeat (3) @(posedge i_ref_clk);
		check("masked irq", o_irq, 1'b0);
		i_ccr_mask <= 2'b00;
		clr_seq();
		check("flag clear", o_header_error_flag, 1'b0);
		strobe(k_hdf);
		m.byte_out(8'h00, 1'b1);
		repeat (40) @(posedge i_ref_clk);
		check("nine low", {o_header_detected, o_rx_full}, 2'b01);
		strobe(k_read);
		strobe(k_mset);
		m.byte_out(8'hF0, 1'b0);
		repeat (60) @(posedge i_ref_clk);
		check("mute fe", {o_mute, o_framing_error_flag}, 2'b10);
		strobe(k_mclr);
		m.byte_out(8'hF0, 1'b0);
		repeat (60) @(posedge i_ref_clk);
		check("active fe", o_framing_error_flag, 1'b1);
		clr_seq();
		i_auto_resync_en <= 1'b1;
		i_header_detect_method <= 1'b1;
		strobe(k_mset);
		m.bit_t = 44;
		header(8'h55);
		check("resync div", o_lin_divider, 12'h02C);
		check("wake", {o_mute, o_header_detected, o_header_error_flag}, 3'b010);
		check("id data", o_rx_data, 8'h3C);
		check("length shown", o_header_length != 8'h00, 1'b1);
		strobe(k_read);
		strobe(k_mset);
		m.brk();
		m.bit_t = 24;
		m.byte_out(8'h55, 1'b1);
		repeat (40) @(posedge i_ref_clk);
		check("blocked", {o_header_error_flag, o_synch_field_state, o_mute}, 3'b111);
		clr_seq();
		check("stays set", o_header_error_flag, 1'b1);
		strobe(k_lsf);
		clr_seq();
		check("recovered", {o_header_error_flag, o_synch_field_state}, 2'b00);
		i_auto_resync_en <= 1'b0;
		strobe(k_mclr);
		m.bit_t = 44;
		m.brk();
		repeat (2600) @(posedge i_ref_clk);
		check("timeout", o_header_error_flag, 1'b1);
		clr_seq();
		strobe(k_hdf);
		header(8'h55);
		check("new header", {o_header_detected, o_header_error_flag}, 2'b10);
		strobe(k_read);
		i_div_update_method <= 1'b1;
		strobe(k_mant);
		check("update waits", o_lin_divider, 12'h02C);
		m.byte_out(8'hA5, 1'b1);
		repeat (60) @(posedge i_ref_clk);
		check("update at char", o_lin_divider, 12'h028);
		check("char data", o_rx_data, 8'hA5);
		test_done();
	end
endmodule // lin_slave_header_resync_test
